// ### hw/line_term_pkg.sv
// constants for the line termination and status register group
package line_term_pkg;

	////////////////////////////////////////////////////////////////////////////
	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] DC_TERMINATION_CONTROL_OFS = 8'h1a;
	localparam logic [7:0] RESERVED_LOCATION_OFS = 8'h1b;
	localparam logic [7:0] LOOP_CURRENT_READING_OFS = 8'h1c;
	localparam logic [7:0] LINE_VOLTAGE_READING_OFS = 8'h1d;
	localparam logic [7:0] EVENT_STATUS_OFS = 8'h40;
	localparam logic [7:0] EVENT_MASK_OFS = 8'h41;

	////////////////////////////////////////////////////////////////////////////
	// dc termination control fields
	localparam int TERM_VOLT_HI = 7;
	localparam int TERM_VOLT_LO = 6;
	localparam int MIN_LOOP_HI = 5;
	localparam int MIN_LOOP_LO = 4;
	localparam int CURRENT_LIMIT_BIT = 1;
	localparam int DC_IMPEDANCE_BIT = 0;
	localparam logic [7:0] DC_TERM_WRITABLE = 8'hf3;

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] DC_TERM_RESET = 8'h00;
	localparam logic [7:0] LOOP_CURRENT_RESET = 8'h00;
	localparam logic [7:0] LINE_VOLTAGE_RESET = 8'h00;
	localparam logic [3:0] EVENT_STATUS_RESET = 4'h0;
	localparam logic [3:0] EVENT_MASK_RESET = 4'h0;
	localparam logic [7:0] READ_ZERO = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// event bits of status and mask
	localparam int EV_POLARITY = 0;
	localparam int EV_NO_LINE = 1;
	localparam int EV_LOOP_LOW = 2;
	localparam int EV_OVER_LIMIT = 3;
	localparam int EV_W = 4;

	////////////////////////////////////////////////////////////////////////////
	// analog meanings of the codes
	localparam logic [11:0] TERM_MV_00 = 12'd3100;
	localparam logic [11:0] TERM_MV_01 = 12'd3200;
	localparam logic [11:0] TERM_MV_10 = 12'd3350;
	localparam logic [11:0] TERM_MV_11 = 12'd3500;
	localparam logic [4:0] MIN_LOOP_MA_00 = 5'd10;
	localparam logic [4:0] MIN_LOOP_MA_01 = 5'd12;
	localparam logic [4:0] MIN_LOOP_MA_10 = 5'd14;
	localparam logic [4:0] MIN_LOOP_MA_11 = 5'd16;
	localparam logic [9:0] DC_OHM_LOW = 10'd50;
	localparam logic [9:0] DC_OHM_HIGH = 10'd800;
	localparam int LIMIT_MA = 60;
	localparam int LOOP_LSB_UA = 1100;
	localparam int LINE_LSB_V = 1;
	localparam logic [7:0] LIMIT_COUNT = 8'(LIMIT_MA * 1000 / LOOP_LSB_UA);

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLOCK_HZ = 50_000_000;
	localparam int SAMPLE_PERIOD_US = 100;
	localparam int SAMPLE_CYCLES = CLOCK_HZ / 1_000_000 * SAMPLE_PERIOD_US;
	localparam int SAMPLE_CNT_W = 13;

endpackage : line_term_pkg

// ### hw/measure_sync.sv
// three-stage synchroniser for a measurement word arriving from the line side
module measure_sync
	import line_term_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out,
	output logic changed
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] held_reg;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// only take a word once two stages agree, so a word caught mid-change is skipped
	always_ff @(posedge clock) begin
		if (!rstn) begin
			held_reg <= INIT;
		end else if (s2_reg == s3_reg) begin
			held_reg <= s3_reg;
		end
	end

	assign sync_out = held_reg;
	assign changed = (s2_reg == s3_reg) && (s3_reg != held_reg);

endmodule : measure_sync

// ### hw/line_termination_status_regs.sv
// dc termination settings and loop current / line voltage readings with event interrupt
//
// Notes on behaviour
// RULE_01: the termination voltage field in bits 7:6 picks 3.1, 3.2, 3.35 or 3.5 V on the termination pin.
// RULE_02: software on the reduced line-side variant only writes pattern 10 to the termination voltage field.
// RULE_03: the minimum loop current field in bits 5:4 picks 10, 12, 14 or 16 mA.
// RULE_04: software on the reduced line-side variant only writes pattern 00 to the minimum loop current field.
// RULE_05: software always writes zero to the reserved bits 3:2 of the dc termination register.
// RULE_06: with the current limit enable bit set loop current is held to 60 mA at most, else no limit applies.
// RULE_07: the dc impedance bit selects 50 ohm when clear and 800 ohm when set.
// RULE_08: software never writes the reserved location after the dc termination register.
// RULE_09: the loop current reading is an unsigned byte with 1.1 mA per count.
// RULE_10: a loop current reading of zero means the loop current is too low for normal operation.
// RULE_11: the line voltage reading is a byte with 1 V per count.
// RULE_12: the line voltage reading is two's complement so its sign gives the polarity.
// RULE_13: the line voltage reading keeps updating both on-hook and off-hook.
// RULE_14: the top bit of the line voltage reading is the polarity and a change of it is a reversal.
// RULE_15: a line voltage reading of zero means no line is connected.
// RULE_16: writes to the two reading registers change neither their contents nor any behaviour.
//
// Added by the designer: the strobed register port.
module line_termination_status_regs
	import line_term_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	input wire logic [7:0] loop_current_adc,
	input wire logic [7:0] line_voltage_adc,
	output logic [1:0] termination_voltage_sel,
	output logic [11:0] termination_pin_mv,
	output logic [1:0] min_loop_current_sel,
	output logic [4:0] min_loop_current_ma,
	output logic current_limit_en,
	output logic [6:0] current_limit_ma,
	output logic current_limit_active,
	output logic dc_impedance_sel,
	output logic [9:0] dc_impedance_ohm,
	output logic [7:0] loop_current_value,
	output logic [18:0] loop_current_ua,
	output logic loop_current_low,
	output logic signed [7:0] line_voltage_value,
	output logic line_polarity,
	output logic no_line,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic [11:0] term_mv(input logic [1:0] code);
		case (code)
			2'b00: term_mv = TERM_MV_00;
			2'b01: term_mv = TERM_MV_01;
			2'b10: term_mv = TERM_MV_10;
			default: term_mv = TERM_MV_11;
		endcase
	endfunction : term_mv

	function automatic logic [4:0] min_loop_ma(input logic [1:0] code);
		case (code)
			2'b00: min_loop_ma = MIN_LOOP_MA_00;
			2'b01: min_loop_ma = MIN_LOOP_MA_01;
			2'b10: min_loop_ma = MIN_LOOP_MA_10;
			default: min_loop_ma = MIN_LOOP_MA_11;
		endcase
	endfunction : min_loop_ma

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	////////////////////////////////////////////////////////////////////////////
	// state

	logic [7:0] dc_term_reg;
	logic [7:0] loop_reg;
	logic [7:0] line_reg;
	logic [EV_W-1:0] status_reg;
	logic [EV_W-1:0] status_next;
	logic [EV_W-1:0] mask_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [SAMPLE_CNT_W-1:0] sample_cnt_reg;
	logic sample_tick;
	logic [7:0] loop_sync;
	logic [7:0] line_sync;
	logic [EV_W-1:0] events;
	logic status_read;

	////////////////////////////////////////////////////////////////////////////
	// measurement inputs cross from the line side

	measure_sync #(
		.WIDTH(8),
		.INIT(LOOP_CURRENT_RESET)
	) u_loop_sync (
		.clock(clock),
		.rstn(rstn),
		.async_in(loop_current_adc),
		.sync_out(loop_sync),
		.changed()
	);

	measure_sync #(
		.WIDTH(8),
		.INIT(LINE_VOLTAGE_RESET)
	) u_line_sync (
		.clock(clock),
		.rstn(rstn),
		.async_in(line_voltage_adc),
		.sync_out(line_sync),
		.changed()
	);

	////////////////////////////////////////////////////////////////////////////
	// sample rate divider

	// readings refresh at a fixed rate so software sees a stable value between ticks
	always_ff @(posedge clock) begin
		if (!rstn) begin
			sample_cnt_reg <= '0;
		end else if (sample_tick) begin
			sample_cnt_reg <= '0;
		end else begin
			sample_cnt_reg <= sample_cnt_reg + 1'b1;
		end
	end

	assign sample_tick = (sample_cnt_reg == SAMPLE_CNT_W'(SAMPLE_CYCLES - 1));

	////////////////////////////////////////////////////////////////////////////
	// dc termination control

	// reserved bits 3:2 are not stored, so they always read back as zero
	always_ff @(posedge clock) begin
		if (!rstn) begin
			dc_term_reg <= DC_TERM_RESET;
		end else if (wr && hit(addr, DC_TERMINATION_CONTROL_OFS)) begin
			dc_term_reg <= wdata & DC_TERM_WRITABLE; // [RULE_05]
		end
	end

	// no check for the reduced variant: the block cannot tell which line side is fitted
	assign termination_voltage_sel = dc_term_reg[TERM_VOLT_HI:TERM_VOLT_LO]; // [RULE_01] [RULE_02]
	assign min_loop_current_sel = dc_term_reg[MIN_LOOP_HI:MIN_LOOP_LO]; // [RULE_03] [RULE_04]
	assign current_limit_en = dc_term_reg[CURRENT_LIMIT_BIT]; // [RULE_06]
	assign dc_impedance_sel = dc_term_reg[DC_IMPEDANCE_BIT]; // [RULE_07]

	assign termination_pin_mv = term_mv(termination_voltage_sel); // [RULE_01]
	assign min_loop_current_ma = min_loop_ma(min_loop_current_sel); // [RULE_03]
	assign dc_impedance_ohm = dc_impedance_sel ? DC_OHM_HIGH : DC_OHM_LOW; // [RULE_07]

	// a limit of zero tells the line side to run unlimited
	assign current_limit_ma = current_limit_en ? 7'(LIMIT_MA) : 7'd0; // [RULE_06]

	////////////////////////////////////////////////////////////////////////////
	// readings

	// only the measurement path loads these, a bus write never does
	always_ff @(posedge clock) begin
		if (!rstn) begin
			loop_reg <= LOOP_CURRENT_RESET;
		end else if (sample_tick) begin
			loop_reg <= loop_sync; // [RULE_09] [RULE_16]
		end
	end

	// no hook state gates this update, it runs in either hook mode
	always_ff @(posedge clock) begin
		if (!rstn) begin
			line_reg <= LINE_VOLTAGE_RESET;
		end else if (sample_tick) begin
			line_reg <= line_sync; // [RULE_11] [RULE_13] [RULE_16]
		end
	end

	assign loop_current_value = loop_reg;
	assign loop_current_ua = 19'(loop_reg * LOOP_LSB_UA); // [RULE_09]
	assign loop_current_low = (loop_reg == 8'h00); // [RULE_10]
	assign line_voltage_value = $signed(line_reg); // [RULE_12]
	assign line_polarity = line_reg[7]; // [RULE_14]
	assign no_line = (line_reg == 8'h00); // [RULE_15]

	// the measured current is above the limit; the clamp itself is analog
	assign current_limit_active = current_limit_en && (loop_reg > LIMIT_COUNT); // [RULE_06]

	////////////////////////////////////////////////////////////////////////////
	// events

	always_comb begin
		events = '0;
		if (sample_tick) begin
			events[EV_POLARITY] = (line_sync[7] != line_reg[7]); // [RULE_14]
			events[EV_NO_LINE] = (line_sync == 8'h00) && (line_reg != 8'h00); // [RULE_15]
			events[EV_LOOP_LOW] = (loop_sync == 8'h00) && (loop_reg != 8'h00); // [RULE_10]
			events[EV_OVER_LIMIT] = current_limit_en && (loop_sync > LIMIT_COUNT)
				&& !(loop_reg > LIMIT_COUNT); // [RULE_06]
		end
	end

	assign status_read = rd && hit(addr, EVENT_STATUS_OFS);

	// a new event in the clearing cycle stays set
	always_comb begin
		status_next = status_reg;
		if (status_read) begin
			status_next = '0;
		end
		status_next = status_next | events;
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			status_reg <= EVENT_STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			mask_reg <= EVENT_MASK_RESET;
		end else if (wr && hit(addr, EVENT_MASK_OFS)) begin
			mask_reg <= wdata[EV_W-1:0];
		end
	end

	assign irq = |(status_reg & mask_reg);

	////////////////////////////////////////////////////////////////////////////
	// read path

	// the reserved location and unmapped addresses answer zero; writes there are dropped
	always_comb begin
		rdata_next = READ_ZERO;
		if (rd) begin
			case (addr)
				DC_TERMINATION_CONTROL_OFS: rdata_next = dc_term_reg;
				RESERVED_LOCATION_OFS: rdata_next = READ_ZERO; // [RULE_08]
				LOOP_CURRENT_READING_OFS: rdata_next = loop_reg; // [RULE_09]
				LINE_VOLTAGE_READING_OFS: rdata_next = line_reg; // [RULE_11]
				EVENT_STATUS_OFS: rdata_next = {{(DATA_W - EV_W){1'b0}}, status_reg};
				EVENT_MASK_OFS: rdata_next = {{(DATA_W - EV_W){1'b0}}, mask_reg};
				default: rdata_next = READ_ZERO;
			endcase
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (!rstn) begin
			rdata_reg <= READ_ZERO;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign rdata = rdata_reg;

endmodule : line_termination_status_regs

// ### sim/line_term_checker.sv
// concurrent checks on the ports of the line termination register group
module line_term_checker
	import line_term_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [1:0] termination_voltage_sel,
	input wire logic [11:0] termination_pin_mv,
	input wire logic [1:0] min_loop_current_sel,
	input wire logic [4:0] min_loop_current_ma,
	input wire logic current_limit_en,
	input wire logic [6:0] current_limit_ma,
	input wire logic current_limit_active,
	input wire logic dc_impedance_sel,
	input wire logic [9:0] dc_impedance_ohm,
	input wire logic [7:0] loop_current_value,
	input wire logic [18:0] loop_current_ua,
	input wire logic loop_current_low,
	input wire logic signed [7:0] line_voltage_value,
	input wire logic line_polarity,
	input wire logic no_line
);
	localparam logic [11:0] MV [4] = '{12'h0c1c, 12'h0c80, 12'h0d16, 12'h0dac};
	localparam logic [4:0] MA [4] = '{5'h0a, 5'h0c, 5'h0e, 5'h10};
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////
	sequence s_term_wr;
		wr && addr == 8'h1a;
	endsequence
	sequence s_rd(logic [7:0] a);
		rd && addr == a;
	endsequence
	////////////////////////////////////////////////////////////////
	a_term_decode:
		assert property (termination_pin_mv == MV[termination_voltage_sel]) else $error("pin voltage decode wrong");
	a_min_decode:
		assert property (min_loop_current_ma == MA[min_loop_current_sel]) else $error("min loop decode wrong");
	a_limit_map:
		assert property (current_limit_ma == (current_limit_en ? 7'h3c : 7'h00)
			&& current_limit_active == (current_limit_en && loop_current_value > 8'h36)) else $error("limit wrong");
	a_impedance_map:
		assert property (dc_impedance_ohm == (dc_impedance_sel ? 10'h320 : 10'h032)) else $error("impedance wrong");
	a_loop_scale:
		assert property (loop_current_ua == 19'(loop_current_value) * 19'h44c) else $error("loop scale wrong");
	a_loop_low:
		assert property (loop_current_low == (loop_current_value == 8'h00)) else $error("loop low flag wrong");
	a_no_line:
		assert property (no_line == (line_voltage_value == 8'h00)) else $error("no line flag wrong");
	a_polarity_bit:
		assert property (line_polarity == line_voltage_value[7]) else $error("polarity bit wrong");
	a_term_write:
		assert property (s_term_wr |=> {termination_voltage_sel, min_loop_current_sel, current_limit_en,
			dc_impedance_sel} == {$past(wdata[7:4]), $past(wdata[1:0])}) else $error("control write lost");
	a_term_read:
		assert property (s_rd(8'h1a) |=> rdata == {termination_voltage_sel, min_loop_current_sel, 2'h0,
			current_limit_en, dc_impedance_sel}) else $error("control readback wrong");
	a_loop_read:
		assert property (s_rd(8'h1c) |=> rdata == $past(loop_current_value)) else $error("loop read wrong");
	a_line_read:
		assert property (s_rd(8'h1d) |=> rdata == $past(line_voltage_value)) else $error("line read wrong");
	a_rsvd_read:
		assert property (s_rd(8'h1b) |=> rdata == 8'h00) else $error("reserved read not zero");
endmodule : line_term_checker

bind line_termination_status_regs line_term_checker i_checker (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata,
	.termination_voltage_sel, .termination_pin_mv, .min_loop_current_sel, .min_loop_current_ma,
	.current_limit_en, .current_limit_ma, .current_limit_active, .dc_impedance_sel, .dc_impedance_ohm,
	.loop_current_value, .loop_current_ua, .loop_current_low, .line_voltage_value, .line_polarity, .no_line);

// ### sim/tb_line_termination_status_regs.sv
// self-checking bench for the line termination register group
module tb_line_termination_status_regs
	import line_term_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, loop_current_adc = 8'h00, line_voltage_adc = 8'h00, rdata;
	logic [1:0] termination_voltage_sel, min_loop_current_sel;
	logic [11:0] termination_pin_mv;
	logic [4:0] min_loop_current_ma;
	logic [6:0] current_limit_ma;
	logic [9:0] dc_impedance_ohm;
	logic [7:0] loop_current_value;
	logic [18:0] loop_current_ua;
	logic signed [7:0] line_voltage_value;
	logic current_limit_en, current_limit_active, dc_impedance_sel, loop_current_low, line_polarity, no_line, irq;
	int error_cnt = 0, cmp_count = 0;
	typedef struct {logic [7:0] wd, rb; logic [11:0] mv; logic [4:0] ma; logic [6:0] lm; logic [9:0] oh;} row_t;
	// software keeps the reserved bits 3:2 at zero in every row
	row_t rows [5] = '{'{8'h00, 8'h00, 12'h0c1c, 5'h0a, 7'h00, 10'h032}, '{8'h53, 8'h53, 12'h0c80, 5'h0c, 7'h3c, 10'h320},
		'{8'ha2, 8'ha2, 12'h0d16, 5'h0e, 7'h3c, 10'h032}, '{8'hf1, 8'hf1, 12'h0dac, 5'h10, 7'h00, 10'h320},
		'{8'h80, 8'h80, 12'h0d16, 5'h0a, 7'h00, 10'h032}}; // reduced variant setting
	always #10 clock = ~clock;
	line_termination_status_regs i_dut (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata, .loop_current_adc,
		.line_voltage_adc, .termination_voltage_sel, .termination_pin_mv, .min_loop_current_sel,
		.min_loop_current_ma, .current_limit_en, .current_limit_ma, .current_limit_active, .dc_impedance_sel,
		.dc_impedance_ohm, .loop_current_value, .loop_current_ua, .loop_current_low, .line_voltage_value,
		.line_polarity, .no_line, .irq);
	////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [7:0] a, input logic [7:0] e, input string n);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(n, e, rdata);
	endtask : rd_reg
	task final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	// readings only move on the slow sample tick, so wait up to 6000 cycles, more than one full 5000-cycle period
	task wait_loop(input logic [7:0] e);
		for (int i = 0; i < 6000 && loop_current_value !== e; i++) begin
			@(posedge clock);
			#1;
		end
		if (loop_current_value !== e) begin
			error_cnt++;
			$display("[FAIL] loop_current_value expected %h seen %h", e, loop_current_value);
			final_report();
		end
	endtask : wait_loop
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			wr_reg(8'h1a, rows[i].wd);
			rd_reg(8'h1a, rows[i].rb, "dc_term");
			chk("pin_mv", rows[i].mv, termination_pin_mv);
			chk("min_ma", rows[i].ma, min_loop_current_ma);
			chk("limit_ma", rows[i].lm, current_limit_ma);
			chk("ohm", rows[i].oh, dc_impedance_ohm);
		end
		$display("test control rows done");
		wr_reg(8'h1a, 8'h02);
		wr_reg(8'h41, 8'h0f);
		loop_current_adc <= 8'h37;
		line_voltage_adc <= 8'hf6;
		wait_loop(8'h37);
		chk("line", 32'hffff_fff6, line_voltage_value);
		chk("polarity", 1'b1, line_polarity);
		chk("loop_ua", 19'hec54, loop_current_ua);
		chk("limit_active", 1'b1, current_limit_active);
		chk("irq", 1'b1, irq);
		rd_reg(8'h40, 8'h09, "status");
		chk("irq", 1'b0, irq);
		wr_reg(8'h1c, 8'haa);
		wr_reg(8'h1d, 8'h55);
		wr_reg(8'h7f, 8'hff); // a write to an unmapped address is dropped
		rd_reg(8'h1c, 8'h37, "loop");
		rd_reg(8'h1d, 8'hf6, "line");
		rd_reg(8'h1b, 8'h00, "reserved");
		rd_reg(8'h7f, 8'h00, "unmapped");
		rd_reg(8'h40, 8'h00, "status");
		$display("test readings done");
		wr_reg(8'h41, 8'h06);
		loop_current_adc <= 8'h00;
		line_voltage_adc <= 8'h00;
		wait_loop(8'h00);
		chk("no_line", 1'b1, no_line);
		chk("loop_low", 1'b1, loop_current_low);
		chk("irq", 1'b1, irq);
		wr_reg(8'h41, 8'h00);
		#1;
		chk("irq masked", 1'b0, irq);
		rd_reg(8'h41, 8'h00, "mask");
		rd_reg(8'h40, 8'h07, "status");
		$display("test line loss done");
		wr_reg(8'h1a, 8'hf3);
		rstn <= 1'b0;
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		rd_reg(8'h1a, 8'h00, "dc_term after reset");
		chk("pin_mv after reset", 12'h0c1c, termination_pin_mv);
		chk("irq after reset", 1'b0, irq);
		$display("test reset done");
		final_report();
	end
endmodule : tb_line_termination_status_regs
